// ---- pochm_pkg.sv ----
// Constants, enumerations and carriers for the configuration sequencer and hybrid-mode selector
package pochm_pkg;

   // Clock and timing
   localparam int CLK_MHZ            = 250;
   localparam int SETTLE_NS          = 10000;
   localparam int SETTLE_CYC         = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int TON_MAX_NS         = 20000;
   localparam int TON_MAX_CYC        = (TON_MAX_NS * CLK_MHZ) / 1000;

   // Resistance boundaries, pin code in 10 ohm units
   localparam logic [11:0] PF_EDGE_LM   = 12'h070;
   localparam logic [11:0] PF_EDGE_MH   = 12'h157;
   localparam logic [11:0] PF_EDGE_HN   = 12'h274;
   localparam logic [11:0] OTP_EDGE_12  = 12'h105;
   localparam logic [11:0] OTP_EDGE_23  = 12'h1AC;

   // Constant-on-time share in eighths of a line cycle
   localparam logic [2:0] SHARE_LOW     = 3'h2;
   localparam logic [2:0] SHARE_MED     = 3'h4;
   localparam logic [2:0] SHARE_HIGH    = 3'h5;
   localparam logic [2:0] SHARE_NONE    = 3'h0;

   // Junction temperatures in degrees C
   localparam logic [7:0] DERATE_T1     = 8'h78;
   localparam logic [7:0] DERATE_T2     = 8'h82;
   localparam logic [7:0] DERATE_T3     = 8'h8C;
   localparam logic [7:0] START_T_LIMIT = 8'h6E;
   localparam int         DERATE_SHIFT  = 2;

   // Register map, byte addresses
   localparam logic [7:0] REG_CC_TARGET = 8'h00;
   localparam logic [7:0] REG_STATUS    = 8'h04;
   localparam logic [7:0] REG_MEASURE   = 8'h08;
   localparam logic [7:0] REG_FEEDBACK  = 8'h0C;
   localparam logic [7:0] REG_TIMING    = 8'h10;
   localparam logic [9:0] CC_TARGET_RST = 10'h200;
   localparam logic [9:0] IPK_REF_RST   = 10'h100;
   localparam logic [15:0] TON_THR_RST  = 16'h0400;

   typedef enum logic [1:0] {PF_LOW, PF_MED, PF_HIGH, PF_NONE} pochm_pf_level_type;
   typedef enum logic [2:0] {ST_WAIT, ST_PF, ST_OTP, ST_TEMP, ST_RUN} pochm_cfg_state_type;
   typedef enum logic [1:0] {SW_IDLE, SW_ON, SW_DEMAG} pochm_sw_state_type;

   typedef struct packed {
      pochm_pf_level_type pf;
      logic [1:0]         otp;
   } pochm_cfg_type;

endpackage

// ---- pochm_top.sv ----
// Start-up configuration sequencer and hybrid constant-current / constant-on-time selector
`timescale 1ns/1ps

// Operation
// - Source current on sense pin, switch off
// - Classify sense resistance to four factor levels
// - Shares 25, 50, 62.5, 0 percent
// - Thermal configuration after factor configuration, switch off
// - Source current on feedback pin, measure
// - Map to three derating levels, keep
// - Derating starts at 120, 130, 140 C
// - Configure once per power-up before soft-start
// - Start only below 110 C, else withhold
// - Capture feedback value each switching cycle
// - Alternate constant-current and constant-on-time segments
// - Hold averaged diode current constant
// - Fixed on-time, critical conduction sets frequency
// - Threshold selects mode by line level
// - Constant on-time copies last current-mode on-time
// - Move threshold to regulate configured share
// - Level four runs current mode always
// - Level four clamps on-time at 20us
module pochm_top
   import pochm_pkg::*;
#(
   parameter int TON_MAX = TON_MAX_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        enable_pin,
   input  wire logic        peak_trip_pin,
   input  wire logic        demag_end_pin,
   input  wire logic        valley_pin,
   output logic             current_sense_config_pin,
   output logic             feedback_thermal_config_pin,
   output logic             adc_start,
   input  wire logic        adc_done,
   input  wire logic [11:0] adc_code,
   input  wire logic [7:0]  temp_code,
   input  wire logic        line_zero,
   input  wire logic        fb_sample_valid,
   input  wire logic [11:0] fb_sample_code,
   output logic             drive_on,
   output logic [9:0]       peak_ref,
   output logic             startup_device_control,
   output logic             softstart_go,
   output logic             derate_active
);

   localparam logic [15:0] TON_LIMIT = 16'(TON_MAX);

   logic [3:0]          sync_a;
   logic [3:0]          sync_b;
   logic                enable_s;
   logic                peak_s;
   logic                demag_s;
   logic                valley_s;
   pochm_cfg_state_type cfg_state;
   pochm_cfg_type       cfg;
   logic [15:0]         settle_cnt;
   logic                meas_started;
   logic [11:0]         pf_code;
   logic [11:0]         otp_code;
   logic                hot_hold;
   logic [9:0]          cc_target;
   logic [11:0]         feedback_value;
   pochm_sw_state_type  sw_state;
   logic                cot_mode;
   logic                peak_in_cot;
   logic [15:0]         on_cnt;
   logic [15:0]         last_cc_ton;
   logic [15:0]         cot_ton;
   logic [15:0]         ton_thresh;
   logic [15:0]         demag_cnt;
   logic [15:0]         period_cnt;
   logic [15:0]         period_last;
   logic [23:0]         line_cnt;
   logic [23:0]         cot_cnt;
   logic [2:0]          share;
   logic [7:0]          derate_temp;
   logic [9:0]          eff_target;
   logic [7:0]          excess;
   logic                on_end;
   logic                run;

   // Pins pass two flops before use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a <= 4'h0;
         sync_b <= 4'h0;
      end else begin
         sync_a <= {valley_pin, demag_end_pin, peak_trip_pin, enable_pin};
         sync_b <= sync_a;
      end
   end
   assign enable_s = sync_b[0];
   assign peak_s   = sync_b[1];
   assign demag_s  = sync_b[2];
   assign valley_s = sync_b[3];

   // Configuration sequence, runs once until the next lockout reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_state    <= ST_WAIT;
         settle_cnt   <= 16'h0000;
         meas_started <= 1'b0;
         adc_start    <= 1'b0;
         pf_code      <= 12'h000;
         otp_code     <= 12'h000;
         cfg          <= '{pf: PF_NONE, otp: 2'h0};
         hot_hold     <= 1'b0;
         softstart_go <= 1'b0;
      end else begin
         adc_start    <= 1'b0;
         softstart_go <= 1'b0;
         case (cfg_state)
            ST_WAIT: begin
               if (enable_s) begin
                  cfg_state <= ST_PF;
               end
            end
            ST_PF, ST_OTP: begin
               // Pin voltage must settle before the conversion
               if (!meas_started && settle_cnt == 16'(SETTLE_CYC - 1)) begin
                  adc_start    <= 1'b1;
                  meas_started <= 1'b1;
               end else if (!meas_started) begin
                  settle_cnt <= settle_cnt + 16'h0001;
               end
               if (meas_started && adc_done) begin
                  meas_started <= 1'b0;
                  settle_cnt   <= 16'h0000;
                  if (cfg_state == ST_PF) begin
                     pf_code   <= adc_code;
                     cfg_state <= ST_OTP;
                     if (adc_code < PF_EDGE_LM) begin
                        cfg.pf <= PF_LOW;
                     end else if (adc_code < PF_EDGE_MH) begin
                        cfg.pf <= PF_MED;
                     end else if (adc_code < PF_EDGE_HN) begin
                        cfg.pf <= PF_HIGH;
                     end else begin
                        cfg.pf <= PF_NONE;
                     end
                  end else begin
                     otp_code  <= adc_code;
                     cfg_state <= ST_TEMP;
                     if (adc_code < OTP_EDGE_12) begin
                        cfg.otp <= 2'h0;
                     end else if (adc_code < OTP_EDGE_23) begin
                        cfg.otp <= 2'h1;
                     end else begin
                        cfg.otp <= 2'h2;
                     end
                  end
               end
            end
            ST_TEMP: begin
               // Too hot: keep waiting here, no switching
               if (temp_code < START_T_LIMIT) begin
                  cfg_state    <= ST_RUN;
                  softstart_go <= 1'b1;
                  hot_hold     <= 1'b0;
               end else begin
                  hot_hold <= 1'b1;
               end
            end
            ST_RUN: begin
               cfg_state <= ST_RUN;
            end
            default: begin
               cfg_state <= ST_WAIT;
            end
         endcase
      end
   end

   assign current_sense_config_pin    = (cfg_state == ST_PF);
   assign feedback_thermal_config_pin = (cfg_state == ST_OTP);
   assign run = (cfg_state == ST_RUN);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         startup_device_control <= 1'b1;
      end else if (run) begin
         startup_device_control <= 1'b0;
      end
   end

   // Derating and share tables
   always_comb begin
      case (cfg.otp)
         2'h0:    derate_temp = DERATE_T1;
         2'h1:    derate_temp = DERATE_T2;
         default: derate_temp = DERATE_T3;
      endcase
      case (cfg.pf)
         PF_LOW:  share = SHARE_LOW;
         PF_MED:  share = SHARE_MED;
         PF_HIGH: share = SHARE_HIGH;
         default: share = SHARE_NONE;
      endcase
   end

   // Current target falls by a fixed slope above the derating point
   always_comb begin
      excess = temp_code - derate_temp;
      if (temp_code <= derate_temp) begin
         eff_target = cc_target;
      end else if ({2'b00, excess} << DERATE_SHIFT >= cc_target) begin
         eff_target = 10'h000;
      end else begin
         eff_target = cc_target - 10'({2'b00, excess} << DERATE_SHIFT);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         derate_active <= 1'b0;
      end else begin
         derate_active <= run && (temp_code > derate_temp);
      end
   end

   // End of on-time: peak trip in current mode, fixed count otherwise
   always_comb begin
      if (on_cnt + 16'h0001 >= TON_LIMIT) begin
         on_end = 1'b1;
      end else if (cot_mode) begin
         on_end = (on_cnt + 16'h0001 >= cot_ton);
      end else begin
         on_end = peak_s;
      end
   end

   // Switching cycle; starts only at a valley after the winding has reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_state    <= SW_IDLE;
         drive_on    <= 1'b0;
         on_cnt      <= 16'h0000;
         demag_cnt   <= 16'h0000;
         period_cnt  <= 16'h0000;
         period_last <= 16'h0000;
         last_cc_ton <= 16'h0000;
         cot_ton     <= 16'h0000;
         cot_mode    <= 1'b0;
         peak_in_cot <= 1'b0;
         peak_ref    <= IPK_REF_RST;
      end else begin
         period_cnt <= (period_cnt == 16'hFFFF) ? period_cnt : period_cnt + 16'h0001;
         case (sw_state)
            SW_IDLE: begin
               if (run && valley_s) begin
                  sw_state    <= SW_ON;
                  drive_on    <= 1'b1;
                  on_cnt      <= 16'h0000;
                  peak_in_cot <= 1'b0;
                  period_last <= period_cnt;
                  period_cnt  <= 16'h0000;
               end
            end
            SW_ON: begin
               on_cnt <= on_cnt + 16'h0001;
               if (cot_mode && peak_s) begin
                  peak_in_cot <= 1'b1;
               end
               if (on_end) begin
                  drive_on  <= 1'b0;
                  sw_state  <= SW_DEMAG;
                  demag_cnt <= 16'h0000;
                  if (!cot_mode) begin
                     last_cc_ton <= on_cnt + 16'h0001;
                  end
               end
            end
            SW_DEMAG: begin
               demag_cnt <= demag_cnt + 16'h0001;
               if (demag_s) begin
                  sw_state <= SW_IDLE;
                  // Mode decided only here, between cycles
                  if (cfg.pf == PF_NONE) begin
                     cot_mode <= 1'b0;
                  end else if (cot_mode) begin
                     cot_mode <= !peak_in_cot;
                  end else if (last_cc_ton >= ton_thresh) begin
                     cot_mode <= 1'b1;
                     cot_ton  <= last_cc_ton;
                  end
                  // Peak x reset time tracks target x period
                  if (!cot_mode) begin
                     if (26'(peak_ref * demag_cnt) > 26'(eff_target * period_last)) begin
                        if (peak_ref != 10'h000) begin
                           peak_ref <= peak_ref - 10'h001;
                        end
                     end else if (peak_ref != 10'h3FF) begin
                        peak_ref <= peak_ref + 10'h001;
                     end
                  end
               end
            end
            default: begin
               sw_state <= SW_IDLE;
               drive_on <= 1'b0;
            end
         endcase
      end
   end

   // Share measured per line cycle; high on-time means low line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_cnt   <= 24'h000000;
         cot_cnt    <= 24'h000000;
         ton_thresh <= TON_THR_RST;
      end else if (line_zero) begin
         line_cnt <= 24'h000000;
         cot_cnt  <= 24'h000000;
         if (run && cfg.pf != PF_NONE) begin
            if ({cot_cnt, 3'b000} > 27'(line_cnt * share)) begin
               if (ton_thresh != 16'hFFFF) begin
                  ton_thresh <= ton_thresh + 16'h0001;
               end
            end else if ({cot_cnt, 3'b000} < 27'(line_cnt * share)) begin
               if (ton_thresh != 16'h0001) begin
                  ton_thresh <= ton_thresh - 16'h0001;
               end
            end
         end
      end else begin
         if (line_cnt != 24'hFFFFFF) begin
            line_cnt <= line_cnt + 24'h000001;
         end
         if (cot_mode && cot_cnt != 24'hFFFFFF) begin
            cot_cnt <= cot_cnt + 24'h000001;
         end
      end
   end

   // Feedback sampled while the secondary conducts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         feedback_value <= 12'h000;
      end else if (fb_sample_valid && sw_state == SW_DEMAG) begin
         feedback_value <= fb_sample_code;
      end
   end

   // APB slave, zero wait states
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !(paddr == REG_CC_TARGET || paddr == REG_STATUS ||
                    paddr == REG_MEASURE || paddr == REG_FEEDBACK || paddr == REG_TIMING);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cc_target <= CC_TARGET_RST;
      end else if (psel && penable && pwrite && paddr == REG_CC_TARGET) begin
         cc_target <= pwdata[9:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable) begin
         case (paddr)
            REG_CC_TARGET: prdata <= {22'h000000, cc_target};
            REG_STATUS:    prdata <= {22'h000000, derate_active, hot_hold, cot_mode,
                                      cfg_state, cfg.otp, cfg.pf};
            REG_MEASURE:   prdata <= {4'h0, otp_code, 4'h0, pf_code};
            REG_FEEDBACK:  prdata <= {20'h00000, feedback_value};
            REG_TIMING:    prdata <= {last_cc_ton, ton_thresh};
            default:       prdata <= 32'h00000000;
         endcase
      end
   end

endmodule

// ---- pochm_checker.sv ----
// Port assertions for the configuration sequencer and hybrid selector
`timescale 1ns/1ps
module pochm_checker
   import pochm_pkg::*;
#(
   parameter int TON_MAX = TON_MAX_CYC
) (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic [7:0] temp_code,
   input wire logic       current_sense_config_pin,
   input wire logic       feedback_thermal_config_pin,
   input wire logic       adc_start,
   input wire logic       drive_on,
   input wire logic       startup_device_control,
   input wire logic       softstart_go,
   input wire logic       derate_active
);
   logic [15:0] on_len;
   logic [1:0]  starts;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Counters instead of long repetitions keep the tools fast
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_len <= 16'h0000;
         starts <= 2'h0;
      end else begin
         on_len <= drive_on ? on_len + 16'h0001 : 16'h0000;
         if (softstart_go && starts != 2'h3) begin
            starts <= starts + 2'h1;
         end
      end
   end

   sequence s_pf_done; $fell(current_sense_config_pin); endsequence
   sequence s_gap; !drive_on [*3]; endsequence

   property p_pf_quiet; current_sense_config_pin |-> !drive_on && !feedback_thermal_config_pin;
   endproperty
   a_pf_quiet: assert property (p_pf_quiet) else $error("factor stage not quiet");
   property p_pf_then_otp; s_pf_done |-> feedback_thermal_config_pin; endproperty
   a_pf_then_otp: assert property (p_pf_then_otp) else $error("no thermal stage");
   property p_otp_quiet; feedback_thermal_config_pin |-> !drive_on; endproperty
   a_otp_quiet: assert property (p_otp_quiet) else $error("drive in thermal stage");
   property p_adc_src;
      adc_start |-> current_sense_config_pin || feedback_thermal_config_pin;
   endproperty
   a_adc_src: assert property (p_adc_src) else $error("conversion without source");
   property p_once; starts <= 2'h1; endproperty
   a_once: assert property (p_once) else $error("second start");
   property p_no_drive; startup_device_control |-> !drive_on; endproperty
   a_no_drive: assert property (p_no_drive) else $error("drive before run");
   property p_hot; temp_code >= START_T_LIMIT |=> !softstart_go; endproperty
   a_hot: assert property (p_hot) else $error("start while hot");
   // Start-up device control drops one clock after the start pulse
   property p_go; softstart_go |-> startup_device_control ##1 !startup_device_control;
   endproperty
   a_go: assert property (p_go) else $error("start pulse misplaced");
   property p_derate;
      derate_active |-> !startup_device_control && $past(temp_code) > DERATE_T1;
   endproperty
   a_derate: assert property (p_derate) else $error("derate without cause");
   property p_clamp; on_len <= TON_MAX; endproperty
   a_clamp: assert property (p_clamp) else $error("on-time over clamp");
   property p_gap; $fell(drive_on) |-> s_gap; endproperty
   a_gap: assert property (p_gap) else $error("retrigger inside cycle");
endmodule

bind pochm_top pochm_checker #(.TON_MAX(TON_MAX)) chk_u (.pclk, .presetn, .temp_code,
   .current_sense_config_pin, .feedback_thermal_config_pin, .adc_start, .drive_on,
   .startup_device_control, .softstart_go, .derate_active);

// ---- pochm_stage_model.sv ----
// Behavioural flyback stage and resistance converter facing the controller
`timescale 1ns/1ps
module pochm_stage_model
   import pochm_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        drive_on,
   input  wire logic        current_sense_config_pin,
   input  wire logic        adc_start,
   input  wire logic [11:0] pf_res,
   input  wire logic [11:0] otp_res,
   input  wire logic [7:0]  trip_cyc,
   output logic             peak_trip_pin,
   output logic             demag_end_pin,
   output logic             valley_pin,
   output logic             adc_done,
   output logic [11:0]      adc_code
);
   logic [7:0] on_cnt;
   logic [7:0] off_cnt;
   logic [3:0] conv_cnt;

   // Code is valid only with done; toggles otherwise so stale reads show
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_cnt <= 4'h0;
         adc_done <= 1'b0;
         adc_code <= 12'hA5A;
      end else begin
         if (adc_start) conv_cnt <= 4'h6;
         else if (conv_cnt != 4'h0) conv_cnt <= conv_cnt - 4'h1;
         adc_done <= conv_cnt == 4'h1;
         if (conv_cnt == 4'h1) begin
            adc_code <= current_sense_config_pin ? pf_res : otp_res;
         end else begin
            adc_code <= ~adc_code;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_cnt  <= 8'h00;
         off_cnt <= 8'hFF;
      end else begin
         on_cnt  <= drive_on ? on_cnt + {7'h00, on_cnt != 8'hFF} : 8'h00;
         off_cnt <= drive_on ? 8'h00 : off_cnt + {7'h00, off_cnt != 8'hFF};
      end
   end
   assign peak_trip_pin = drive_on && on_cnt >= trip_cyc;
   assign demag_end_pin = !drive_on && off_cnt >= 8'h0A;
   assign valley_pin    = !drive_on && off_cnt >= 8'h0E;
endmodule

// ---- tb_top.sv ----
// Bench: configuration levels, start-up gate, switching and register access
`timescale 1ns/1ps
module tb_top
   import pochm_pkg::*;
;
   localparam logic [11:0] PF_CODE [4] = '{PF_EDGE_LM - 12'h001, PF_EDGE_MH - 12'h001,
                                           PF_EDGE_HN - 12'h001, PF_EDGE_HN};
   localparam logic [11:0] OTP_CODE [4] = '{OTP_EDGE_12 - 12'h001, OTP_EDGE_12,
                                            OTP_EDGE_23, OTP_EDGE_23 - 12'h001};
   localparam logic [1:0]  OTP_LVL [4] = '{2'h0, 2'h1, 2'h2, 2'h1};
   localparam logic [7:0]  DT [3] = '{DERATE_T1, DERATE_T2, DERATE_T3};

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        enable_pin, peak_trip_pin, demag_end_pin, valley_pin, adc_start, adc_done;
   logic        current_sense_config_pin, feedback_thermal_config_pin, line_zero, line_on;
   logic        fb_sample_valid, drive_on, startup_device_control, softstart_go, derate_active;
   logic [7:0]  paddr, temp_code, trip_cyc;
   logic [31:0] pwdata, prdata, q;
   logic [11:0] adc_code, fb_sample_code, pf_res, otp_res;
   logic [9:0]  peak_ref;
   logic [5:0]  lz_cnt;
   int          num_errors, checks_done, i, n;

   pochm_top #(.TON_MAX(50)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .enable_pin, .peak_trip_pin, .demag_end_pin,
      .valley_pin, .current_sense_config_pin, .feedback_thermal_config_pin, .adc_start,
      .adc_done, .adc_code, .temp_code, .line_zero, .fb_sample_valid, .fb_sample_code,
      .drive_on, .peak_ref, .startup_device_control, .softstart_go, .derate_active);
   pochm_stage_model stage_u (.pclk, .presetn, .drive_on, .current_sense_config_pin,
      .adc_start, .pf_res, .otp_res, .trip_cyc, .peak_trip_pin, .demag_end_pin, .valley_pin,
      .adc_done, .adc_code);

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // Line-cycle marks every 64 clocks, only while switching is wanted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lz_cnt    <= 6'h00;
         line_zero <= 1'b0;
      end else begin
         lz_cnt    <= lz_cnt + 6'h01;
         line_zero <= line_on && lz_cnt == 6'h00;
      end
   end

   task automatic give_verdict();
      if (num_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic fail_out();
      num_errors++;
      give_verdict();
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) fail_out();
      q   = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fb_sample_valid = 1'b1;
      fb_sample_code = 12'h5A5;
      num_errors = 0;
      checks_done = 0;
      for (i = 0; i < 4; i++) begin
         pf_res     <= PF_CODE[i];
         otp_res    <= OTP_CODE[i];
         temp_code  <= (i == 0) ? START_T_LIMIT : 8'h19;
         trip_cyc   <= (i == 3) ? 8'hC8 : 8'h14;
         line_on    <= 1'b0;
         presetn    <= 1'b0;
         enable_pin <= 1'b0;
         repeat (8) @(posedge pclk);
         presetn    <= 1'b1;
         enable_pin <= 1'b1;
         if (i == 0) begin
            apb(1'b0, REG_CC_TARGET, 32'h0);
            chk(q, {22'h0, CC_TARGET_RST});
            chk(peak_ref, IPK_REF_RST);
            apb(1'b1, REG_STATUS, 32'hFFFFFFFF);
            apb(1'b0, REG_STATUS, 32'h0);
            chk(q[1:0], 2'h3);
            apb(1'b1, REG_CC_TARGET, 32'hFFFFFFFF);
            apb(1'b0, REG_CC_TARGET, 32'h0);
            chk(q, 32'h3FF);
            apb(1'b0, 8'h14, 32'h0);
            chk(q, 32'h0);
            chk(err, 1'b1);
            apb(1'b0, REG_TIMING, 32'h0);
            chk(q[15:0], TON_THR_RST);
            q = 32'h0;
            for (n = 0; n < 4000 && q[6:4] !== 3'h3; n++) apb(1'b0, REG_STATUS, 32'h0);
            if (n == 4000) fail_out();
            // Exactly 110 C must keep the start withheld
            repeat (20) @(posedge pclk);
            apb(1'b0, REG_STATUS, 32'h0);
            chk({q[8], q[6:4], startup_device_control}, {1'b1, 3'h3, 1'b1});
            temp_code <= START_T_LIMIT - 8'h01;
         end
         for (n = 0; n < 20000 && softstart_go !== 1'b1; n++) @(posedge pclk);
         if (n == 20000) fail_out();
         apb(1'b0, REG_STATUS, 32'h0);
         chk(q[6:0], {3'h4, OTP_LVL[i], i[1:0]});
         apb(1'b0, REG_MEASURE, 32'h0);
         chk(q, {4'h0, OTP_CODE[i], 4'h0, PF_CODE[i]});
         line_on <= 1'b1;
         repeat (8000) @(posedge pclk);
         // Light load: reset time times peak stays under target, so the peak rises
         chk(peak_ref > IPK_REF_RST, 1'b1);
         apb(1'b0, REG_FEEDBACK, 32'h0);
         chk(q[11:0], 12'h5A5);
         apb(1'b0, REG_TIMING, 32'h0);
         if (i == 3) chk(q[15:0], TON_THR_RST);
         else chk(q[15:0] < TON_THR_RST, 1'b1);
         apb(1'b0, REG_STATUS, 32'h0);
         if (i == 3) chk(q[7], 1'b0);
         temp_code <= DT[OTP_LVL[i]];
         repeat (4) @(posedge pclk);
         chk(derate_active, 1'b0);
         temp_code <= DT[OTP_LVL[i]] + 8'h01;
         repeat (4) @(posedge pclk);
         chk(derate_active, 1'b1);
      end
      give_verdict();
   end
endmodule
